// >>> core/sys_status_regs.sv
/*
 * System status and configuration register bank of the controller,
 * reached over AXI4-Lite, with event interrupt, reply delay timer and
 * operand address unit.
 * Assumes the execution status inputs come from controller logic on
 * REF_CLK_IN, so they are not synchronised.
 */
// Decided for this implementation: the address map and the AXI4-Lite register port.
// What this block does
// - Timer flag high only during timer routine
// - Four I/O flags, each tracks own routine
// - Hold flag shows hold; writing requests hold
// - Sub-program word bit 0 tracks sub-program one
// - Save count 0 to 2048, resets 2048
// - Reply delay 0 to 30, steps 10 ms
// - Operand address direct or index modified
// - Three identical signed 16-bit index registers
`timescale 1ns/1ps
module sys_status_regs #(
	parameter int UNIT_CYCLES = sys_status_pkg::REPLY_STEP_CYC
) (
	input wire logic REF_CLK_IN,
	input wire logic RST_IN,
	// AXI4-Lite slave
	input wire logic [sys_status_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [sys_status_pkg::DATA_W-1:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [sys_status_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [sys_status_pkg::DATA_W-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Execution status from the controller core
	input wire logic TIMER_IRQ_ACTIVE_IN,
	input wire logic [sys_status_pkg::NUM_IO-1:0] IO_IRQ_ACTIVE_IN,
	input wire logic SUBPROGRAM1_ACTIVE_IN,
	input wire logic HOLD_ACTIVE_IN,
	// Serial port side
	input wire logic [7:0] FREE_TEXT_STATUS_IN,
	input wire logic REPLY_REQ_IN,
	output logic REPLY_GO_OUT,
	output logic REPLY_BUSY_OUT,
	output logic [15:0] SERIAL_MODE_OUT,
	output logic [7:0] FREE_TEXT_CTRL_OUT,
	// Persistent save and hold
	output logic [15:0] SAVE_COUNT_OUT,
	output logic HOLD_REQ_OUT,
	// Operand addressing
	input wire logic [15:0] OPERAND_BASE_IN,
	input wire logic OPERAND_INDEXED_IN,
	input wire logic [1:0] OPERAND_INDEX_SEL_IN,
	output logic [15:0] OPERAND_ADDR_OUT,
	// Interrupt
	output logic IRQ_OUT
);
	import sys_status_pkg::*;

	// Write channel holding state
	logic aw_full_q; // Write address captured
	logic w_full_q; // Write data captured
	logic [7:0] awaddr_q; // Captured write address
	logic [31:0] wdata_q; // Captured write data
	logic [3:0] wstrb_q; // Captured strobes
	logic bvalid_q; // Write response pending
	logic [1:0] bresp_q; // Write response code
	// Read channel state
	logic rvalid_q; // Read data pending
	logic [31:0] rdata_q; // Read data register
	logic [1:0] rresp_q; // Read response code
	// Register storage
	logic hold_req_q; // Hold request from software
	logic [15:0] save_q; // Persistent save count
	logic [15:0] opsel_q; // Serial port mode word
	logic [15:0] delay_q; // Reply delay in 10 ms steps
	logic [7:0] free_ctrl_q; // Free text control bits
	logic [15:0] idx_q [3]; // Index registers I, J, K
	logic [NUM_EV-1:0] ev_stat_q; // Sticky event bits
	logic [NUM_EV-1:0] ev_en_q; // Event enables
	logic [4:0] act_prev_q; // Last activity levels
	logic hold_prev_q; // Last hold level
	// Reply delay timer
	logic [REPLY_CNT_W-1:0] cnt_q; // Cycles left in this step
	logic [4:0] left_q; // Steps left
	logic busy_q; // Timer running
	logic go_q; // Reply may go now

	// Decode wires
	logic aw_hs; // Address handshake now
	logic w_hs; // Data handshake now
	logic aw_have; // Address available
	logic w_have; // Data available
	logic do_write; // Commit a write this cycle
	logic [7:0] wr_addr; // Write address in use
	logic [31:0] wr_data; // Write data in use
	logic [3:0] wr_strb; // Strobes in use
	logic wr_hit; // Write address mapped
	logic ar_hs; // Read address handshake
	logic rd_hit; // Read address mapped
	logic [15:0] rd_word; // Selected read word
	logic [15:0] flags_w; // Flag word as read
	logic [15:0] wr_word; // Lane-merged write word
	logic [15:0] wr_base; // Current value of target
	logic [4:0] act_now; // Activity levels now
	logic [NUM_EV-1:0] ev_set; // Events this cycle
	logic [NUM_EV-1:0] ev_clr; // Software clears
	logic start_ok; // Reply request accepted
	logic step_end; // Current step done

	// Handshakes; one write at a time until response is taken
	assign S_AXI_AWREADY = !aw_full_q && !bvalid_q;
	assign S_AXI_WREADY = !w_full_q && !bvalid_q;
	assign aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
	assign w_hs = S_AXI_WVALID && S_AXI_WREADY;
	assign aw_have = aw_full_q || aw_hs;
	assign w_have = w_full_q || w_hs;
	assign do_write = aw_have && w_have;
	assign wr_addr = aw_full_q ? awaddr_q : S_AXI_AWADDR;
	assign wr_data = w_full_q ? wdata_q : S_AXI_WDATA;
	assign wr_strb = w_full_q ? wstrb_q : S_AXI_WSTRB;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;

	// Read channel; one read at a time
	assign S_AXI_ARREADY = !rvalid_q;
	assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;

	// Flag word: reserved bits tie to zero
	assign flags_w = {10'h000, HOLD_ACTIVE_IN || hold_req_q,
		IO_IRQ_ACTIVE_IN, TIMER_IRQ_ACTIVE_IN};

	// Read selection; unmapped and reserved words give zero
	assign rd_hit = S_AXI_ARADDR == OFS_FLAGS ||
		S_AXI_ARADDR == OFS_SUBPROG || S_AXI_ARADDR == OFS_SAVE_COUNT ||
		S_AXI_ARADDR == OFS_OP_SELECT ||
		S_AXI_ARADDR == OFS_REPLY_DELAY ||
		S_AXI_ARADDR == OFS_FREE_TEXT || S_AXI_ARADDR == OFS_INDEX_I ||
		S_AXI_ARADDR == OFS_INDEX_J || S_AXI_ARADDR == OFS_INDEX_K ||
		S_AXI_ARADDR == OFS_IRQ_STATUS || S_AXI_ARADDR == OFS_IRQ_CLEAR ||
		S_AXI_ARADDR == OFS_IRQ_ENABLE;
	assign rd_word =
		(S_AXI_ARADDR == OFS_FLAGS) ? flags_w :
		(S_AXI_ARADDR == OFS_SUBPROG) ?
			{15'h0000, SUBPROGRAM1_ACTIVE_IN} :
		(S_AXI_ARADDR == OFS_SAVE_COUNT) ? save_q :
		(S_AXI_ARADDR == OFS_OP_SELECT) ? opsel_q :
		(S_AXI_ARADDR == OFS_REPLY_DELAY) ? delay_q :
		(S_AXI_ARADDR == OFS_FREE_TEXT) ?
			{FREE_TEXT_STATUS_IN, free_ctrl_q} :
		(S_AXI_ARADDR == OFS_INDEX_I) ? idx_q[0] :
		(S_AXI_ARADDR == OFS_INDEX_J) ? idx_q[1] :
		(S_AXI_ARADDR == OFS_INDEX_K) ? idx_q[2] :
		(S_AXI_ARADDR == OFS_IRQ_STATUS) ? {9'h000, ev_stat_q} :
		(S_AXI_ARADDR == OFS_IRQ_ENABLE) ? {9'h000, ev_en_q} :
		16'h0000;

	// Write target and byte-lane merge; upper lanes are ignored
	assign wr_hit = wr_addr == OFS_FLAGS ||
		wr_addr == OFS_SUBPROG || wr_addr == OFS_SAVE_COUNT ||
		wr_addr == OFS_OP_SELECT || wr_addr == OFS_REPLY_DELAY ||
		wr_addr == OFS_FREE_TEXT || wr_addr == OFS_INDEX_I ||
		wr_addr == OFS_INDEX_J || wr_addr == OFS_INDEX_K ||
		wr_addr == OFS_IRQ_STATUS || wr_addr == OFS_IRQ_CLEAR ||
		wr_addr == OFS_IRQ_ENABLE;
	assign wr_base =
		(wr_addr == OFS_FLAGS) ? {10'h000, hold_req_q, 5'h00} :
		(wr_addr == OFS_SAVE_COUNT) ? save_q :
		(wr_addr == OFS_OP_SELECT) ? opsel_q :
		(wr_addr == OFS_REPLY_DELAY) ? delay_q :
		(wr_addr == OFS_FREE_TEXT) ? {8'h00, free_ctrl_q} :
		(wr_addr == OFS_INDEX_I) ? idx_q[0] :
		(wr_addr == OFS_INDEX_J) ? idx_q[1] :
		(wr_addr == OFS_INDEX_K) ? idx_q[2] :
		(wr_addr == OFS_IRQ_ENABLE) ? {9'h000, ev_en_q} : 16'h0000;
	assign wr_word = {wr_strb[1] ? wr_data[15:8] : wr_base[15:8],
		wr_strb[0] ? wr_data[7:0] : wr_base[7:0]};

	// Write handshake bookkeeping
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			aw_full_q <= aw_have && !do_write;
			w_full_q <= w_have && !do_write;
			// Response follows both halves
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Captured write payload; no reset needed for data path
	always_ff @(posedge REF_CLK_IN) begin
		if (aw_hs) begin
			awaddr_q <= S_AXI_AWADDR;
		end
		if (w_hs) begin
			wdata_q <= S_AXI_WDATA;
			wstrb_q <= S_AXI_WSTRB;
		end
	end

	// Read answer one cycle after address is taken
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_q <= 1'b1;
			rdata_q <= {16'h0000, rd_word};
			rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	// Configuration words; out-of-range values clamp to the limit
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			hold_req_q <= 1'b0;
			save_q <= SAVE_COUNT_RST;
			opsel_q <= OP_SELECT_RST;
			delay_q <= REPLY_DELAY_RST;
			free_ctrl_q <= FREE_CTRL_RST;
			ev_en_q <= '0;
		end else if (do_write) begin
			case (wr_addr)
				OFS_FLAGS: begin
					hold_req_q <= wr_word[FLG_HOLD];
				end
				OFS_SAVE_COUNT: begin
					save_q <= (wr_word > SAVE_COUNT_MAX) ?
						SAVE_COUNT_MAX : wr_word;
				end
				OFS_OP_SELECT: begin
					opsel_q <= wr_word;
				end
				OFS_REPLY_DELAY: begin
					delay_q <= (wr_word > REPLY_DELAY_MAX) ?
						REPLY_DELAY_MAX : wr_word;
				end
				OFS_FREE_TEXT: begin
					free_ctrl_q <= wr_word[7:0];
				end
				OFS_IRQ_ENABLE: begin
					ev_en_q <= wr_word[NUM_EV-1:0];
				end
				default: begin
					// Read-only and reserved words drop writes
				end
			endcase
		end
	end

	// Three identical index registers
	genvar gi;
	for (gi = 0; gi < 3; gi++) begin : g_idx
		localparam logic [7:0] OFS = OFS_INDEX_I + 8'(4 * gi);
		// Signed 16-bit store, any pattern legal
		always_ff @(posedge REF_CLK_IN) begin
			if (RST_IN) begin
				idx_q[gi] <= INDEX_RST;
			end else if (do_write && wr_addr == OFS) begin
				idx_q[gi] <= wr_word;
			end
		end
	end

	// Events: routine start on each activity flag, hold entry, reply
	assign act_now = {IO_IRQ_ACTIVE_IN, TIMER_IRQ_ACTIVE_IN};
	assign ev_set = {go_q, HOLD_ACTIVE_IN && !hold_prev_q,
		act_now & ~act_prev_q};
	assign ev_clr = (do_write && wr_addr == OFS_IRQ_CLEAR) ?
		wr_word[NUM_EV-1:0] : '0;
	assign IRQ_OUT = |(ev_stat_q & ev_en_q);

	// Sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			ev_stat_q <= '0;
			act_prev_q <= 5'h00;
			hold_prev_q <= 1'b0;
		end else begin
			ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
			act_prev_q <= act_now;
			hold_prev_q <= HOLD_ACTIVE_IN;
		end
	end

	// Reply delay: delay_q steps of UNIT_CYCLES each
	assign start_ok = REPLY_REQ_IN && !busy_q;
	assign step_end = busy_q && cnt_q == '0;
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			busy_q <= 1'b0;
			go_q <= 1'b0;
			cnt_q <= '0;
			left_q <= 5'h00;
		end else if (start_ok) begin
			// Zero delay answers at once
			busy_q <= delay_q != 16'h0000;
			go_q <= delay_q == 16'h0000;
			cnt_q <= REPLY_CNT_W'(UNIT_CYCLES - 1);
			left_q <= delay_q[4:0];
		end else if (step_end) begin
			// Last step ends the wait
			busy_q <= left_q != 5'h01;
			go_q <= left_q == 5'h01;
			cnt_q <= REPLY_CNT_W'(UNIT_CYCLES - 1);
			left_q <= 5'(left_q - 5'h01);
		end else begin
			go_q <= 1'b0;
			cnt_q <= busy_q ? REPLY_CNT_W'(cnt_q - 1'b1) : cnt_q;
		end
	end

	// Output drive
	assign REPLY_GO_OUT = go_q;
	assign REPLY_BUSY_OUT = busy_q;
	assign SERIAL_MODE_OUT = opsel_q;
	assign FREE_TEXT_CTRL_OUT = free_ctrl_q;
	assign SAVE_COUNT_OUT = save_q;
	assign HOLD_REQ_OUT = hold_req_q;

	// Effective operand address; range is the program's care
	operand_addr_unit u_addr (
		.clk_in(REF_CLK_IN),
		.rst_in(RST_IN),
		.base_in(OPERAND_BASE_IN),
		.indexed_in(OPERAND_INDEXED_IN),
		.sel_in(OPERAND_INDEX_SEL_IN),
		.idx_i_in(idx_q[0]),
		.idx_j_in(idx_q[1]),
		.idx_k_in(idx_q[2]),
		.addr_out(OPERAND_ADDR_OUT)
	);

	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (RST_IN);

	// Timer flag read back matches routine state
	property p_timer_flag;
		ar_hs && S_AXI_ARADDR == OFS_FLAGS |=>
			S_AXI_RDATA[FLG_TIMER] == $past(TIMER_IRQ_ACTIVE_IN);
	endproperty
	a_timer_flag: assert property (p_timer_flag)
		else $error("timer flag readback wrong");

	// Each I/O flag follows its own source
	property p_io_flags;
		ar_hs && S_AXI_ARADDR == OFS_FLAGS |=>
			S_AXI_RDATA[FLG_IO_LO+:NUM_IO] == $past(IO_IRQ_ACTIVE_IN);
	endproperty
	a_io_flags: assert property (p_io_flags)
		else $error("io flag readback wrong");

	// Writing the hold bit requests hold next cycle
	property p_hold_req;
		do_write && wr_addr == OFS_FLAGS && wr_strb[0] |=>
			HOLD_REQ_OUT == $past(wr_data[FLG_HOLD]);
	endproperty
	a_hold_req: assert property (p_hold_req)
		else $error("hold request not taken");

	// Sub-program bit and zero upper bits
	property p_subprog;
		ar_hs && S_AXI_ARADDR == OFS_SUBPROG |=>
			S_AXI_RDATA == {31'h0, $past(SUBPROGRAM1_ACTIVE_IN)};
	endproperty
	a_subprog: assert property (p_subprog)
		else $error("sub-program word wrong");

	// Save count never exceeds its limit
	property p_save_max;
		SAVE_COUNT_OUT <= SAVE_COUNT_MAX;
	endproperty
	a_save_max: assert property (p_save_max)
		else $error("save count above limit");

	// Reply delay register never exceeds 30
	property p_delay_max;
		delay_q <= REPLY_DELAY_MAX;
	endproperty
	a_delay_max: assert property (p_delay_max)
		else $error("reply delay above limit");

	// Zero delay: answer next cycle, timer stays idle
	property p_reply_zero;
		start_ok && delay_q == 16'h0000 |=>
			REPLY_GO_OUT && !REPLY_BUSY_OUT;
	endproperty
	a_reply_zero: assert property (p_reply_zero)
		else $error("zero delay reply late");

	// Unmapped read gives zero and an error
	property p_unmapped;
		ar_hs && !rd_hit |=>
			S_AXI_RDATA == 32'h0 && S_AXI_RRESP == RESP_SLVERR;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	// Main scenarios
	c_hold_write: cover property (do_write && wr_addr == OFS_FLAGS);
	c_reply_go: cover property (busy_q ##1 REPLY_GO_OUT);
	c_irq: cover property ($rose(IRQ_OUT));
endmodule

// >>> include/sys_status_pkg.sv
/*
 * Constants for the controller system status register bank: register
 * byte offsets, field positions, reset values, limits and timing.
 * Assumes a 250 MHz register clock and a 32-bit AXI4-Lite bus.
 */
package sys_status_pkg;

	// Bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;

	// Register byte offsets
	localparam logic [7:0] OFS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_SUBPROG = 8'h04;
	localparam logic [7:0] OFS_SAVE_COUNT = 8'h08;
	localparam logic [7:0] OFS_OP_SELECT = 8'h0C;
	localparam logic [7:0] OFS_REPLY_DELAY = 8'h10;
	localparam logic [7:0] OFS_FREE_TEXT = 8'h14;
	localparam logic [7:0] OFS_INDEX_I = 8'h18;
	localparam logic [7:0] OFS_INDEX_J = 8'h1C;
	localparam logic [7:0] OFS_INDEX_K = 8'h20;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h28;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h2C;

	// Flag word fields
	localparam int FLG_TIMER = 0;
	localparam int FLG_IO_LO = 1;
	localparam int NUM_IO = 4;
	localparam int FLG_HOLD = 5;

	// Interrupt event bit positions
	localparam int EV_TIMER = 0;
	localparam int EV_HOLD = 5;
	localparam int EV_REPLY = 6;
	localparam int NUM_EV = 7;

	// Reset values and limits
	localparam logic [15:0] SAVE_COUNT_RST = 16'h0800;
	localparam logic [15:0] SAVE_COUNT_MAX = 16'h0800;
	localparam logic [15:0] REPLY_DELAY_RST = 16'h0000;
	localparam logic [15:0] REPLY_DELAY_MAX = 16'h001E;
	localparam logic [15:0] OP_SELECT_RST = 16'h0000;
	localparam logic [7:0] FREE_CTRL_RST = 8'h00;
	localparam logic [15:0] INDEX_RST = 16'h0000;

	// Index register selector codes
	localparam logic [1:0] IDX_SEL_I = 2'h0;
	localparam logic [1:0] IDX_SEL_J = 2'h1;
	localparam logic [1:0] IDX_SEL_K = 2'h2;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing: reply delay step of 10 ms at a 4 ns clock
	localparam int CLK_PERIOD_NS = 4;
	localparam int REPLY_STEP_MS = 10;
	localparam int REPLY_STEP_CYC = REPLY_STEP_MS * 1000000 / CLK_PERIOD_NS;
	localparam int REPLY_CNT_W = 22;

endpackage

// >>> core/operand_addr_unit.sv
/*
 * Operand address unit: forms the effective operand address, either the
 * literal base or the base plus one signed index register.
 * Assumes the index registers come from the same clock domain.
 */
`timescale 1ns/1ps
module operand_addr_unit (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [15:0] base_in,
	input wire logic indexed_in,
	input wire logic [1:0] sel_in,
	input wire logic [15:0] idx_i_in,
	input wire logic [15:0] idx_j_in,
	input wire logic [15:0] idx_k_in,
	output logic [15:0] addr_out
);
	import sys_status_pkg::*;

	logic [15:0] idx_w; // Selected index value
	logic [15:0] addr_d; // Next effective address
	logic [15:0] addr_q; // Registered address

	// Pick one of three identical index registers
	assign idx_w = (sel_in == IDX_SEL_I) ? idx_i_in :
		(sel_in == IDX_SEL_J) ? idx_j_in :
		(sel_in == IDX_SEL_K) ? idx_k_in : INDEX_RST;
	// Direct or index-modified; wraps silently, no range
	assign addr_d = indexed_in ? 16'(base_in + idx_w) : base_in;
	assign addr_out = addr_q;

	// Address register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			addr_q <= 16'h0000;
		end else begin
			addr_q <= addr_d;
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_indexed_i;
		indexed_in && sel_in == IDX_SEL_I |=>
			addr_out == 16'($past(base_in) + $past(idx_i_in));
	endproperty
	a_indexed_i: assert property (p_indexed_i)
		else $error("indexed address with I is wrong");
endmodule

// >>> tb/tb_sys_status_regs.sv
/*
 * Self-checking bench for the system status register bank: AXI4-Lite
 * read and write tasks and directed tests of flags, config and timing.
 * Assumes the bank answers within the watchdog span and UNIT_CYCLES 3.
 */
`timescale 1ns/1ps
module tb_sys_status_regs;
	import sys_status_pkg::*;
	localparam int UNIT = 3; // Short reply step keeps the run brief
	logic clk = 1'b0;
	logic rst = 1'b1;
	// Register bus master side
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF; // Byte lanes; narrowed for the lane test
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	// Controller side drives
	logic tmr = 1'b0, sub = 1'b0, hold = 1'b0, req = 1'b0, ix = 1'b0;
	logic [3:0] io = 4'h0;
	logic [7:0] ft_st = 8'hA5; // Status byte seen in free text word
	logic [1:0] sel = 2'h0;
	logic [15:0] base = 16'h000A;
	// Observed outputs
	logic [15:0] mode, save, addr;
	logic [7:0] ft_ctrl;
	logic go, busy, hold_req, irq;
	int n_errors = 0;
	int comparisons = 0;
	int dl [3] = '{0, 1, 30}; // Reply delays, both ends of the range

	sys_status_regs #(.UNIT_CYCLES(UNIT)) dut (
		.REF_CLK_IN(clk), .RST_IN(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.TIMER_IRQ_ACTIVE_IN(tmr), .IO_IRQ_ACTIVE_IN(io),
		.SUBPROGRAM1_ACTIVE_IN(sub), .HOLD_ACTIVE_IN(hold),
		.FREE_TEXT_STATUS_IN(ft_st), .REPLY_REQ_IN(req),
		.REPLY_GO_OUT(go), .REPLY_BUSY_OUT(busy),
		.SERIAL_MODE_OUT(mode), .FREE_TEXT_CTRL_OUT(ft_ctrl),
		.SAVE_COUNT_OUT(save), .HOLD_REQ_OUT(hold_req),
		.OPERAND_BASE_IN(base), .OPERAND_INDEXED_IN(ix),
		.OPERAND_INDEX_SEL_IN(sel), .OPERAND_ADDR_OUT(addr),
		.IRQ_OUT(irq)
	);

	// Free running 250 MHz clock
	initial begin
		forever #2 clk = ~clk;
	end

	// Compare one value and count it
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Write one word; halves released as each is taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (!ad && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
		chk("write resp", {30'h0, er}, {30'h0, bresp});
	endtask

	// Read one word and compare data and response
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er, input string nm);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
		chk(nm, e, rdata);
		chk("read resp", {30'h0, er}, {30'h0, rresp});
	endtask

	// Operand address appears one cycle after its inputs
	task automatic op(input logic x, input logic [1:0] s,
		input logic [15:0] e);
		@(posedge clk);
		ix <= x;
		sel <= s;
		@(posedge clk);
		@(negedge clk);
		chk("operand address", {16'h0, e}, {16'h0, addr});
	endtask

	// Request a reply and count cycles until the go pulse
	task automatic reply(input int d);
		int n;
		n = 0;
		@(posedge clk);
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		do begin
			@(negedge clk);
			n++;
			if (n == 1 && d > 0)
				chk("reply busy", 32'h1, {31'h0, busy});
		end while (!go && n < 200);
		chk("reply wait", (d == 0) ? 1 : d * UNIT + 1, n);
		@(negedge clk);
		chk("go width", 32'h0, {31'h0, go});
	endtask

	// Verdict and end of run, shared with the watchdog
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog: tests need a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("Watchdog expired before the tests ended");
		end_of_test();
	end

	// Main test sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_SAVE_COUNT, 32'h800, RESP_OKAY, "save reset");
		chk("save out", 32'h800, {16'h0, save});
		rd(OFS_REPLY_DELAY, 32'h0, RESP_OKAY, "delay reset");
		rd(OFS_FLAGS, 32'h0, RESP_OKAY, "flags idle");
		$display("Test reset values done");
		// Execution flags follow their inputs
		tmr <= 1'b1;
		rd(OFS_FLAGS, 32'h1, RESP_OKAY, "timer flag");
		tmr <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			io <= 4'h1 << i;
			rd(OFS_FLAGS, 32'h2 << i, RESP_OKAY, "io flag");
		end
		io <= 4'h0;
		rd(OFS_FLAGS, 32'h0, RESP_OKAY, "flags clear");
		hold <= 1'b1;
		rd(OFS_FLAGS, 32'h20, RESP_OKAY, "hold flag");
		hold <= 1'b0;
		rd(OFS_FLAGS, 32'h0, RESP_OKAY, "hold off");
		wr(OFS_FLAGS, 32'hFFFF, RESP_OKAY);
		rd(OFS_FLAGS, 32'h20, RESP_OKAY, "hold write");
		chk("hold request", 32'h1, {31'h0, hold_req});
		sub <= 1'b1;
		rd(OFS_SUBPROG, 32'h1, RESP_OKAY, "subprog on");
		wr(OFS_SUBPROG, 32'hFFFF, RESP_OKAY);
		rd(OFS_SUBPROG, 32'h1, RESP_OKAY, "subprog ro");
		sub <= 1'b0;
		rd(OFS_SUBPROG, 32'h0, RESP_OKAY, "subprog off");
		$display("Test status flags done");
		// Configuration words and their limits
		wr(OFS_SAVE_COUNT, 32'h0, RESP_OKAY);
		rd(OFS_SAVE_COUNT, 32'h0, RESP_OKAY, "save min");
		wstrb <= 4'h2;
		wr(OFS_SAVE_COUNT, 32'h0355, RESP_OKAY);
		wstrb <= 4'hF;
		rd(OFS_SAVE_COUNT, 32'h300, RESP_OKAY, "save lane");
		wr(OFS_SAVE_COUNT, 32'hFFFF, RESP_OKAY);
		rd(OFS_SAVE_COUNT, 32'h800, RESP_OKAY, "save clamp");
		wr(OFS_REPLY_DELAY, 32'h1F, RESP_OKAY);
		rd(OFS_REPLY_DELAY, 32'h1E, RESP_OKAY, "delay clamp");
		wr(OFS_OP_SELECT, 32'h1234, RESP_OKAY);
		chk("serial mode", 32'h1234, {16'h0, mode});
		wr(OFS_FREE_TEXT, 32'h3C, RESP_OKAY);
		rd(OFS_FREE_TEXT, 32'hA53C, RESP_OKAY, "free text");
		chk("free ctrl", 32'h3C, {24'h0, ft_ctrl});
		$display("Test config words done");
		// Reply delay in steps of the unit
		foreach (dl[i]) begin
			wr(OFS_REPLY_DELAY, dl[i], RESP_OKAY);
			reply(dl[i]);
		end
		$display("Test reply delay done");
		// Index registers hold signed words, all alike
		wr(OFS_INDEX_I, 32'hFFFF, RESP_OKAY);
		wr(OFS_INDEX_J, 32'h7FFF, RESP_OKAY);
		wr(OFS_INDEX_K, 32'h8000, RESP_OKAY);
		rd(OFS_INDEX_I, 32'hFFFF, RESP_OKAY, "index i");
		rd(OFS_INDEX_J, 32'h7FFF, RESP_OKAY, "index j");
		rd(OFS_INDEX_K, 32'h8000, RESP_OKAY, "index k");
		op(1'b0, IDX_SEL_J, 16'h000A);
		op(1'b1, IDX_SEL_I, 16'h0009);
		op(1'b1, IDX_SEL_J, 16'h8009);
		op(1'b1, IDX_SEL_K, 16'h800A);
		op(1'b1, 2'h3, 16'h000A);
		$display("Test operand address done");
		// Unmapped and write-only places
		rd(8'h30, 32'h0, RESP_SLVERR, "unmapped read");
		wr(8'h30, 32'hFFFF, RESP_SLVERR);
		wr(OFS_IRQ_CLEAR, 32'h7F, RESP_OKAY);
		rd(OFS_IRQ_CLEAR, 32'h0, RESP_OKAY, "clear reads zero");
		// Interrupt raise, clear and mask
		wr(OFS_IRQ_ENABLE, 32'h1, RESP_OKAY);
		rd(OFS_IRQ_ENABLE, 32'h1, RESP_OKAY, "irq enable");
		tmr <= 1'b1;
		rd(OFS_IRQ_STATUS, 32'h1, RESP_OKAY, "timer event");
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(OFS_IRQ_CLEAR, 32'h1, RESP_OKAY);
		rd(OFS_IRQ_STATUS, 32'h0, RESP_OKAY, "event cleared");
		chk("irq cleared", 32'h0, {31'h0, irq});
		tmr <= 1'b0;
		io <= 4'h1;
		rd(OFS_IRQ_STATUS, 32'h2, RESP_OKAY, "io event");
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(OFS_IRQ_ENABLE, 32'h2, RESP_OKAY);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		io <= 4'h0;
		wr(OFS_IRQ_CLEAR, 32'h7F, RESP_OKAY);
		chk("irq final", 32'h0, {31'h0, irq});
		// Hold entry and reply go also latch events
		hold <= 1'b1;
		rd(OFS_IRQ_STATUS, 32'h20, RESP_OKAY, "hold event");
		hold <= 1'b0;
		wr(OFS_REPLY_DELAY, 32'h0, RESP_OKAY);
		reply(0);
		rd(OFS_IRQ_STATUS, 32'h60, RESP_OKAY, "reply event");
		chk("irq still masked", 32'h0, {31'h0, irq});
		$display("Test interrupts done");
		// Reset in mid-run brings back the reset values
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_SAVE_COUNT, 32'h800, RESP_OKAY, "save again");
		rd(OFS_FLAGS, 32'h0, RESP_OKAY, "hold req reset");
		rd(OFS_IRQ_STATUS, 32'h0, RESP_OKAY, "events reset");
		rd(OFS_INDEX_K, 32'h0, RESP_OKAY, "index reset");
		chk("hold request off", 32'h0, {31'h0, hold_req});
		chk("save out again", 32'h800, {16'h0, save});
		$display("Test reset in mid-run done");
		end_of_test();
	end
endmodule
